// ===== common/risc_exec_map.svh
// Encodings, offsets and field positions of the execute block
// How it works
// - Extended format: opcode, two registers, sub-opcode
// - Three-register format adds reg3 in 20..16
// - 16-bit no-operand format with one sub bit
// - Block transfers move exactly four words
// - Conditional branch adds disp9 when condition holds
// - Fast branches: same conditions, flags untouched
// - ADD register or imm5 into reg2, carry, overflow, sign and zero flags
// - Three-operand add: reg1 plus imm16 into reg2
// - AND clears overflow, leaves carry alone
// - Immediate AND zero-extends, clears overflow and sign
// - Compare subtracts, sets flags, stores nothing
// - Interrupt enable/disable never touches NMI
// - Signed divide: quotient reg2, remainder r30
// - Unsigned divide clears overflow, remainder r30
// - Halt sleeps and keeps all flags
// - Port input zero-extends, aligns the address
// - Loads sign-extend, align the address
// - Jump-and-link writes PC plus 4 to r31
// - Relative jump adds disp26, no link
// - Register jump clears address bit 0
// - System load copies reg2 into system register
// - Multiply-accumulate saturates, sets saturation flag
// - Low half fetched from the lower address
// - Branch disp9 bit 0 always zero
`ifndef RISC_EXEC_MAP_SVH
`define RISC_EXEC_MAP_SVH
`define RESET_PC     32'h0000_0000
`define OP_ADD_R     6'h01
`define OP_COMP_R    6'h03
`define OP_JIND      6'h06
`define OP_DIV       6'h09
`define OP_UDIV      6'h0b
`define OP_AND_R     6'h0d
`define OP_ADD_I     6'h11
`define OP_COMP_I    6'h13
`define OP_INTCTL    6'h16
`define OP_HALT      6'h1a
`define OP_SRLD      6'h1c
`define OP_JREL      6'h30
`define OP_JLNK      6'h31
`define OP_ADD16     6'h32
`define OP_AND16     6'h33
`define OP_EXT       6'h3e
`define LONG_TAG     2'h3
`define BCOND_OP     3'h4
`define SUB_MACC     6'h04
`define SUB_BLK_TAG  4'h0
`define SIZE_BYTE    2'h0
`define SIZE_HALF    2'h1
`define SREG_PSW     5'h05
`define PSW_Z        0
`define PSW_S        1
`define PSW_V        2
`define PSW_C        3
`define PSW_SF       4
`define STAT_SLEEP   5
`define STAT_IE      6
`define R_REMAINDER  5'h1e
`define R_LINK       5'h1f
`define HOST_PC      6'h20
`define HOST_STATUS  6'h21
`define BEAT_LAST    2'h3
`define MAX_POS      32'h7fff_ffff
`define MAX_NEG      32'h8000_0000
`endif

// ===== common/risc_exec_pkg.sv
// Types shared by the execute block
`default_nettype none
package risc_exec_pkg;
  // Sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_FETCH_LO = 6'h01,
    ST_FETCH_HI = 6'h02,
    ST_EXEC     = 6'h04,
    ST_MEM      = 6'h08,
    ST_BLOCK    = 6'h10,
    ST_SLEEP    = 6'h20
  } exec_state_t;
  // Every flip-flop of the core except the register file and RAMs
  typedef struct packed {
    exec_state_t state;
    logic [31:0] pc;
    logic [31:0] ir;
    logic        c;
    logic        v;
    logic        s;
    logic        z;
    logic        sf;
    logic        int_enable;
    logic [1:0]  beat;
    logic        mem_req;
    logic        mem_we;
    logic        mem_io;
    logic [1:0]  mem_size;
    logic [31:0] mem_addr;
    logic [31:0] mem_wdata;
    logic        sreg_we;
    logic [4:0]  sreg_num;
    logic [31:0] sreg_wdata;
    logic [31:0] host_rdata;
  } exec_regs_t;
endpackage
`default_nettype wire

// ===== logic/sign_extend.sv
// Sign extension of a narrow field to a word
`timescale 1ns/1ps
`default_nettype none
module sign_extend #(
  parameter int W = 16  // Width of the field
) (
  input  wire logic [W-1:0] din,   // Narrow field
  output logic      [31:0]  dout   // Extended word
);
  // Copy the top bit into every upper position
  assign dout = {{(32-W){din[W-1]}}, din};
endmodule
`default_nettype wire

// ===== logic/branch_condition.sv
// Branch condition evaluation from the four flags
`timescale 1ns/1ps
`default_nettype none
module branch_condition (
  input  wire logic [3:0] cond,  // Condition code, bit 3 negates
  input  wire logic       c,     // Carry
  input  wire logic       v,     // Overflow
  input  wire logic       s,     // Sign
  input  wire logic       z,     // Zero
  output logic            take   // Condition holds
);
  logic base;  // Condition before negation
  // Base term picked by the low three bits
  always_comb begin
    case (cond[2:0])
      3'h0:    base = v;
      3'h1:    base = c;
      3'h2:    base = z;
      3'h3:    base = c | z;
      3'h4:    base = s;
      3'h5:    base = 1'b1;
      3'h6:    base = s ^ v;
      default: base = (s ^ v) | z;
    endcase
  end
  // Upper half of the codes is the negated set
  assign take = base ^ cond[3];
endmodule
`default_nettype wire

// ===== logic/risc_instruction_execute.sv
// Fetch, decode and execute sequencer with register file
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "risc_exec_map.svh"
module risc_instruction_execute
  import risc_exec_pkg::*;
(
  input  wire logic        core_clk,         // Core clock
  input  wire logic        resetn,           // Async reset
  output logic             mem_req,          // Bus request
  output logic             mem_we,           // Write access
  output logic             mem_io,           // Port space
  output logic [1:0]       mem_size,         // Access size
  output logic [31:0]      mem_addr,         // Byte address
  output logic [31:0]      mem_wdata,        // Write data
  input  wire logic [31:0] mem_rdata,        // Read data
  input  wire logic        mem_ack,          // Access done
  input  wire logic [5:0]  host_addr,        // Host address
  input  wire logic [31:0] host_wdata,       // Host write data
  input  wire logic        host_we,          // Host write
  input  wire logic        host_re,          // Host read
  output logic [31:0]      host_rdata,       // Host read data
  output logic             sysreg_we,        // System reg write
  output logic [4:0]       sysreg_num,       // System reg number
  output logic [31:0]      sysreg_wdata,     // System reg data
  output logic             carry_flag,       // Carry
  output logic             overflow_flag,    // Overflow
  output logic             sign_flag,        // Sign
  output logic             zero_flag,        // Zero
  output logic             saturation_flag,  // Sticky saturation
  output logic             int_enable,       // Maskable enable
  output logic             sleeping          // Halted
);

  // State after reset: fetch from the reset vector
  localparam exec_regs_t REGS_RST = '{
    state:    ST_FETCH_LO,
    pc:       `RESET_PC,
    mem_req:  1'b1,
    mem_addr: `RESET_PC,
    mem_size: `SIZE_HALF,
    default:  '0
  };

  exec_regs_t  r;                 // Current state
  exec_regs_t  next_r;            // Next state
  logic [31:0] rf [32];           // General registers
  logic [31:0] dram [64];         // On-chip data RAM
  logic [31:0] iram [64];         // On-chip instruction RAM

  logic [5:0]  op;                // Primary opcode
  logic [5:0]  subop;             // Secondary opcode
  logic [4:0]  f_r1;              // reg1 field
  logic [4:0]  f_r2;              // reg2 field
  logic [4:0]  f_r3;              // reg3 field
  logic [31:0] a1;                // reg1 value
  logic [31:0] a2;                // reg2 value
  logic [31:0] a3;                // reg3 value
  logic [31:0] imm5x;             // Extended imm5
  logic [31:0] disp9x;            // Extended disp9
  logic [31:0] imm16x;            // Extended imm16
  logic [31:0] disp26x;           // Extended disp26
  logic        take;              // Branch condition holds
  logic [5:0]  rd_idx;            // On-chip RAM read index
  logic [31:0] ram_q;             // On-chip RAM read word
  logic        go_fetch;          // Start next fetch
  logic [31:0] npc;               // Next PC
  logic [31:0] pc_seq;            // Sequential next PC
  logic [33:0] t;                 // Carry, overflow, result
  logic [31:0] res;               // Logic or load result
  logic [63:0] prod;              // MAC product and sum
  logic [31:0] status;            // Host status word
  logic        wa_en;             // Write port A enable
  logic [4:0]  wa;                // Write port A index
  logic [31:0] wa_d;              // Write port A data
  logic        wb_en;             // Write port B enable
  logic [4:0]  wb;                // Write port B index
  logic [31:0] wb_d;              // Write port B data
  logic        ram_we;            // On-chip RAM write

  // Add with carry out and signed overflow
  function automatic logic [33:0] add_f(input logic [31:0] x,
                                        input logic [31:0] y);
    logic [32:0] u;
    u = {1'b0, x} + {1'b0, y};
    add_f = {u[32], (x[31] == y[31]) && (u[31] != x[31]), u[31:0]};
  endfunction

  // Subtract with borrow out and signed overflow
  function automatic logic [33:0] sub_f(input logic [31:0] x,
                                        input logic [31:0] y);
    logic [32:0] u;
    u = {1'b0, x} - {1'b0, y};
    sub_f = {u[32], (x[31] != y[31]) && (u[31] != x[31]), u[31:0]};
  endfunction

  // Field split; subop and reg3 sit inside the imm16 bits 31..16
  assign op    = r.ir[15:10];
  assign f_r2  = r.ir[9:5];
  assign f_r1  = r.ir[4:0];
  assign subop = r.ir[31:26];
  assign f_r3  = r.ir[20:16];
  assign a1    = rf[f_r1];
  assign a2    = rf[f_r2];
  assign a3    = rf[f_r3];

  // Immediate and displacement extenders
  sign_extend #(.W(5)) u_imm5 (
    .din  (r.ir[4:0]),
    .dout (imm5x)
  );
  sign_extend #(.W(9)) u_disp9 (
    .din  ({r.ir[8:1], 1'b0}),
    .dout (disp9x)
  );
  sign_extend #(.W(16)) u_imm16 (
    .din  (r.ir[31:16]),
    .dout (imm16x)
  );
  sign_extend #(.W(26)) u_disp26 (
    .din  ({r.ir[9:0], r.ir[31:17], 1'b0}),
    .dout (disp26x)
  );

  // One evaluator serves both branch families
  branch_condition u_cond (
    .cond (r.ir[12:9]),
    .c    (r.c),
    .v    (r.v),
    .s    (r.s),
    .z    (r.z),
    .take (take)
  );

  // RAM word for a block store: base on entry, next word later
  assign rd_idx = a2[7:2] + (r.state == ST_BLOCK ?
                  {4'h0, r.beat} + 6'h01 : 6'h00);
  assign ram_q  = subop[1] ? iram[rd_idx] : dram[rd_idx];
  assign pc_seq = r.pc + (r.ir[15:14] == `LONG_TAG ? 32'h4 : 32'h2);

  // Status word seen by the host
  always_comb begin
    status               = 32'h0;
    status[`PSW_Z]       = r.z;
    status[`PSW_S]       = r.s;
    status[`PSW_V]       = r.v;
    status[`PSW_C]       = r.c;
    status[`PSW_SF]      = r.sf;
    status[`STAT_SLEEP]  = (r.state == ST_SLEEP);
    status[`STAT_IE]     = r.int_enable;
  end

  // Next-state logic; flags are copied unless an op names them
  always_comb begin
    next_r   = r;
    next_r.sreg_we = 1'b0;
    go_fetch = 1'b0;
    npc      = pc_seq;
    t        = 34'h0;
    res      = 32'h0;
    prod     = 64'h0;
    wa_en    = 1'b0;
    wa       = `R_REMAINDER;
    wa_d     = 32'h0;
    wb_en    = 1'b0;
    wb       = f_r2;
    wb_d     = 32'h0;
    ram_we   = 1'b0;
    // Read data stands only in the cycle after the strobe
    next_r.host_rdata = 32'h0;
    if (host_re) begin
      if (!host_addr[5])
        next_r.host_rdata = rf[host_addr[4:0]];
      else if (host_addr == `HOST_PC)
        next_r.host_rdata = r.pc;
      else if (host_addr == `HOST_STATUS)
        next_r.host_rdata = status;
    end
    case (r.state)
      // Low half comes from the lower address
      ST_FETCH_LO: begin
        if (mem_ack) begin
          next_r.ir = {16'h0, mem_rdata[15:0]};
          if (mem_rdata[15:14] == `LONG_TAG) begin
            next_r.mem_addr = r.pc + 32'h2;
            next_r.state    = ST_FETCH_HI;
          end else begin
            next_r.mem_req = 1'b0;
            next_r.state   = ST_EXEC;
          end
        end
      end
      // High half from the next halfword
      ST_FETCH_HI: begin
        if (mem_ack) begin
          next_r.ir[31:16] = mem_rdata[15:0];
          next_r.mem_req   = 1'b0;
          next_r.state     = ST_EXEC;
        end
      end
      // One-cycle execution of the decoded op
      ST_EXEC: begin
        go_fetch = 1'b1;
        if (r.ir[15:13] == `BCOND_OP) begin
          // Bit 0 picks the fast family; neither touches flags
          if (take)
            npc = r.pc + disp9x;
        end else begin
          case (op)
            `OP_ADD_R, `OP_ADD_I, `OP_ADD16: begin
              if (op == `OP_ADD16)
                t = add_f(a1, imm16x);
              else
                t = add_f(a2, op == `OP_ADD_I ? imm5x : a1);
              wb_en     = 1'b1;
              wb_d      = t[31:0];
              next_r.c  = t[33];
              next_r.v  = t[32];
              next_r.s  = t[31];
              next_r.z  = (t[31:0] == 32'h0);
            end
            `OP_COMP_R, `OP_COMP_I: begin
              // Result is dropped, only flags change
              t = sub_f(a2, op == `OP_COMP_I ? imm5x : a1);
              next_r.c  = t[33];
              next_r.v  = t[32];
              next_r.s  = t[31];
              next_r.z  = (t[31:0] == 32'h0);
            end
            `OP_AND_R: begin
              res       = a2 & a1;
              wb_en     = 1'b1;
              wb_d      = res;
              next_r.v  = 1'b0;
              next_r.s  = res[31];
              next_r.z  = (res == 32'h0);
            end
            `OP_AND16: begin
              res       = a1 & {16'h0, r.ir[31:16]};
              wb_en     = 1'b1;
              wb_d      = res;
              next_r.v  = 1'b0;
              next_r.s  = 1'b0;
              next_r.z  = (res == 32'h0);
            end
            `OP_INTCTL: begin
              // Only the maskable enable; NMI has no gate here
              next_r.int_enable = r.ir[0];
            end
            `OP_DIV: begin
              // Zero divisor leaves registers and flags alone
              if (a1 != 32'h0) begin
                wa_en = 1'b1;
                wb_en = 1'b1;
                if (a2 == `MAX_NEG && a1 == 32'hffff_ffff) begin
                  wb_d      = a2;
                  wa_d      = 32'h0;
                  next_r.v  = 1'b1;
                end else begin
                  wb_d      = $signed(a2) / $signed(a1);
                  wa_d      = $signed(a2) % $signed(a1);
                  next_r.v  = 1'b0;
                end
                next_r.s = wb_d[31];
                next_r.z = (wb_d == 32'h0);
              end
            end
            `OP_UDIV: begin
              if (a1 != 32'h0) begin
                wa_en     = 1'b1;
                wb_en     = 1'b1;
                wb_d      = a2 / a1;
                wa_d      = a2 % a1;
                next_r.v  = 1'b0;
                next_r.s  = wb_d[31];
                next_r.z  = (wb_d == 32'h0);
              end
            end
            `OP_HALT: begin
              // Sleep until the host wakes the core; flags kept
              go_fetch     = 1'b0;
              next_r.pc    = pc_seq;
              next_r.state = ST_SLEEP;
            end
            `OP_JIND: begin
              npc = {a1[31:1], 1'b0};
            end
            `OP_JREL: begin
              npc = r.pc + disp26x;
            end
            `OP_JLNK: begin
              wb_en = 1'b1;
              wb    = `R_LINK;
              wb_d  = r.pc + 32'h4;
              npc   = r.pc + disp26x;
            end
            `OP_SRLD: begin
              next_r.sreg_we    = 1'b1;
              next_r.sreg_num   = f_r1;
              next_r.sreg_wdata = a2;
              // Loading the status word rewrites the flags
              if (f_r1 == `SREG_PSW) begin
                next_r.z   = a2[`PSW_Z];
                next_r.s   = a2[`PSW_S];
                next_r.v   = a2[`PSW_V];
                next_r.c   = a2[`PSW_C];
                next_r.sf  = a2[`PSW_SF];
              end
            end
            `OP_EXT: begin
              if (subop[5:2] == `SUB_BLK_TAG) begin
                // Bit 0 stores, bit 1 picks instruction RAM
                go_fetch         = 1'b0;
                next_r.state     = ST_BLOCK;
                next_r.beat      = 2'h0;
                next_r.mem_req   = 1'b1;
                next_r.mem_we    = subop[0];
                next_r.mem_io    = 1'b0;
                next_r.mem_size  = 2'h3;
                next_r.mem_addr  = {a1[31:2], 2'h0};
                next_r.mem_wdata = ram_q;
              end else if (subop == `SUB_MACC) begin
                prod  = $signed(a1) * $signed(a2);
                prod  = prod + {{32{a3[31]}}, a3};
                wb_en = 1'b1;
                wb    = f_r3;
                // Saturate when the sum leaves the word range
                if (prod[63:31] != {33{prod[63]}}) begin
                  next_r.sf  = 1'b1;
                  wb_d = prod[63] ? `MAX_NEG : `MAX_POS;
                end else begin
                  wb_d = prod[31:0];
                end
              end
            end
            default: begin
              // Unknown codes act as no operation
              res = 32'h0;
            end
          endcase
        end
        // Loads and port input start a data access
        if (r.ir[15:14] == `LONG_TAG && op[5:4] == 2'h3
            && (op[3] ^ op[2]) && op != `OP_EXT) begin
          go_fetch         = 1'b0;
          next_r.state     = ST_MEM;
          next_r.mem_req   = 1'b1;
          next_r.mem_we    = 1'b0;
          next_r.mem_io    = op[3];
          next_r.mem_size  = op[1:0];
          next_r.mem_addr  = a1 + imm16x;
          if (op[0])
            next_r.mem_addr[0] = 1'b0;
          if (op[1])
            next_r.mem_addr[1] = 1'b0;
        end
      end
      // Data return: port data zero-extended, memory sign-extended
      ST_MEM: begin
        if (mem_ack) begin
          case (r.mem_size)
            `SIZE_BYTE:
              res = r.mem_io ? {24'h0, mem_rdata[7:0]}
                             : {{24{mem_rdata[7]}}, mem_rdata[7:0]};
            `SIZE_HALF:
              res = r.mem_io ? {16'h0, mem_rdata[15:0]}
                             : {{16{mem_rdata[15]}}, mem_rdata[15:0]};
            default:
              res = mem_rdata;
          endcase
          wb_en    = 1'b1;
          wb_d     = res;
          go_fetch = 1'b1;
        end
      end
      // Four word beats between external and on-chip RAM
      ST_BLOCK: begin
        if (mem_ack) begin
          ram_we = !r.mem_we;
          if (r.beat == `BEAT_LAST) begin
            go_fetch = 1'b1;
          end else begin
            next_r.beat      = r.beat + 2'h1;
            next_r.mem_addr  = r.mem_addr + 32'h4;
            next_r.mem_wdata = ram_q;
          end
        end
      end
      // Host wake write restarts at the saved PC
      ST_SLEEP: begin
        if (host_we && host_addr == `HOST_STATUS && host_wdata[0]) begin
          go_fetch = 1'b1;
          npc      = r.pc;
        end
      end
      default: begin
        go_fetch = 1'b1;
        npc      = r.pc;
      end
    endcase
    // Host may move the PC; the write is taken only while asleep
    if (host_we && host_addr == `HOST_PC && r.state == ST_SLEEP) begin
      next_r.pc = host_wdata;
      npc       = host_wdata;
    end
    // Every path back to fetch goes through here
    if (go_fetch) begin
      next_r.pc       = npc;
      next_r.state    = ST_FETCH_LO;
      next_r.mem_req  = 1'b1;
      next_r.mem_we   = 1'b0;
      next_r.mem_io   = 1'b0;
      next_r.mem_size = `SIZE_HALF;
      next_r.mem_addr = npc;
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      r <= REGS_RST;
    end else begin
      r <= next_r;
    end
  end

  // Register file and RAMs; core writes win over the host
  always_ff @(posedge core_clk) begin
    if (host_we && !host_addr[5])
      rf[host_addr[4:0]] <= host_wdata;
    if (wa_en)
      rf[wa] <= wa_d;
    if (wb_en)
      rf[wb] <= wb_d;
    if (ram_we && subop[1])
      iram[a2[7:2] + {4'h0, r.beat}] <= mem_rdata;
    if (ram_we && !subop[1])
      dram[a2[7:2] + {4'h0, r.beat}] <= mem_rdata;
  end

  // Outputs straight from flip-flops; sleeping decodes the state
  assign mem_req         = r.mem_req;
  assign mem_we          = r.mem_we;
  assign mem_io          = r.mem_io;
  assign mem_size        = r.mem_size;
  assign mem_addr        = r.mem_addr;
  assign mem_wdata       = r.mem_wdata;
  assign host_rdata      = r.host_rdata;
  assign sysreg_we       = r.sreg_we;
  assign sysreg_num      = r.sreg_num;
  assign sysreg_wdata    = r.sreg_wdata;
  assign carry_flag      = r.c;
  assign overflow_flag   = r.v;
  assign sign_flag       = r.s;
  assign zero_flag       = r.z;
  assign saturation_flag = r.sf;
  assign int_enable      = r.int_enable;
  assign sleeping        = (r.state == ST_SLEEP);

endmodule
`default_nettype wire

// ===== sim/mem_model.sv
// Behavioural external memory answering the core's bus
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  input  wire logic        core_clk,  // Core clock
  input  wire logic        mem_req,   // Request
  input  wire logic [1:0]  mem_size,  // Size
  input  wire logic [31:0] mem_addr,  // Address
  output logic      [31:0] mem_rdata, // Read data
  output logic             mem_ack    // Done
);
  logic [15:0] m [0:255];   // Halfwords, index addr[8:1]
  logic [7:0]  cnt = 8'h00; // Free count for stalls and noise
  logic [15:0] lo;          // Halfword at the address
  // Answer only when cnt[1] is high, so delays vary
  always @(posedge core_clk) begin
    cnt <= cnt + 8'h01;
    mem_ack <= mem_req & ~mem_ack & cnt[1];
  end
  // Idle data keeps changing so no stale value passes
  always_comb begin
    lo = m[mem_addr[8:1]];
    if (!mem_ack) mem_rdata = {4{cnt}};
    else if (mem_size == 2'h3) mem_rdata = {m[mem_addr[8:1] + 8'h01], lo};
    else if (mem_size == 2'h1) mem_rdata = {16'h0000, lo};
    else mem_rdata = {24'h000000, mem_addr[0] ? lo[15:8] : lo[7:0]};
  end
endmodule
`default_nettype wire

// ===== sim/risc_exec_checker.sv
// Port assertions of the execute block
`timescale 1ns/1ps
`default_nettype none
module risc_exec_checker (
  input wire logic        core_clk,        // Clock
  input wire logic        resetn,          // Reset
  input wire logic        mem_req,         // Request
  input wire logic        mem_we,          // Write
  input wire logic [1:0]  mem_size,        // Size
  input wire logic [31:0] mem_addr,        // Address
  input wire logic        mem_ack,         // Done
  input wire logic        sysreg_we,       // Sysreg pulse
  input wire logic        saturation_flag, // Sticky flag
  input wire logic        sleeping         // Halted
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  property p_half; mem_req && mem_size == 2'h1 |-> !mem_addr[0]; endproperty
  a_half: assert property (p_half) else $error("odd half address");
  property p_word; mem_req && mem_size == 2'h3 |-> mem_addr[1:0] == 2'h0; endproperty
  a_word: assert property (p_word) else $error("unaligned word");
  // A pending access may not move before its answer
  property p_hold; mem_req && !mem_ack |=> mem_req && $stable(mem_addr); endproperty
  a_hold: assert property (p_hold) else $error("request moved");
  property p_kind; mem_req && !mem_ack |=> $stable(mem_size) && $stable(mem_we); endproperty
  a_kind: assert property (p_kind) else $error("size moved");
  property p_idle; sleeping |-> !mem_req; endproperty
  a_idle: assert property (p_idle) else $error("bus busy asleep");
  // Saturation only falls through a system register write
  property p_sat; saturation_flag |=> saturation_flag || sysreg_we || $past(sysreg_we); endproperty
  a_sat: assert property (p_sat) else $error("saturation lost");
  property p_pulse; sysreg_we |=> !sysreg_we; endproperty
  a_pulse: assert property (p_pulse) else $error("long sysreg pulse");
  property p_store; mem_req && mem_we |-> mem_size == 2'h3; endproperty
  a_store: assert property (p_store) else $error("narrow store");
endmodule
bind risc_instruction_execute risc_exec_checker chk (.*);
`default_nettype wire

// ===== sim/risc_instruction_execute_tb_top.sv
// Bench: short programs run from memory, results read by host
`timescale 1ns/1ps
`default_nettype none
`include "risc_exec_map.svh"
module risc_instruction_execute_tb_top;
  localparam logic [15:0] HLT = {`OP_HALT, 10'h000}; // Halt word
  logic core_clk = 1'b0, resetn = 1'b0, host_we = 1'b0, host_re = 1'b0;
  logic [5:0] host_addr = 6'h00;
  logic [31:0] host_wdata = 32'h0, mem_rdata, mem_addr, mem_wdata, host_rdata, sysreg_wdata;
  logic mem_req, mem_we, mem_io, mem_ack, sysreg_we, carry_flag, overflow_flag;
  logic sign_flag, zero_flag, saturation_flag, int_enable, sleeping;
  logic [1:0] mem_size;
  logic [4:0] sysreg_num;
  int n_mismatch = 0, tests_run = 0;
  logic [31:0] seed = 32'h8d9f8654, a, b, q, got;
  logic [3:0] fl;        // Expected carry, overflow, sign, zero
  logic ie = 1'b0;       // Expected interrupt enable
  risc_instruction_execute uut (.*);
  mem_model mem (.*);
  always #12.5 core_clk = ~core_clk;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Status word while asleep
  function automatic logic [31:0] st();
    return {25'h0, ie, 2'b10, fl};
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      $display("ERROR %0t got %h want %h", $time, g, e);
      n_mismatch++;
    end
  endtask
  task automatic hw(input logic [5:0] ad, input logic [31:0] d);
    @(posedge core_clk);
    host_addr <= ad;
    host_wdata <= d;
    host_we <= 1'b1;
    @(posedge core_clk);
    host_we <= 1'b0;
  endtask
  task automatic chk(input logic [5:0] ad, input logic [31:0] e);
    @(posedge core_clk);
    host_addr <= ad;
    host_re <= 1'b1;
    @(posedge core_clk);
    host_re <= 1'b0;
    #1 cmp(host_rdata, e);
  endtask
  // Bounded wait for the halt at the end of a program
  task automatic slp();
    for (int k = 0; k < 500 && sleeping !== 1'b1; k++) @(negedge core_clk);
    if (sleeping !== 1'b1) begin
      n_mismatch++;
      wrap_up();
    end
  endtask
  // Six halfwords from address 2, entered by a wake from halt
  task automatic run(input logic [95:0] p);
    for (int i = 0; i < 6; i++) mem.m[i+1] = p[95-16*i -: 16];
    hw(`HOST_PC, 32'h2);
    hw(`HOST_STATUS, 32'h1);
    repeat (2) @(negedge core_clk);
    slp();
    $display("test done at %0t", $time);
  endtask
  initial begin
    for (int i = 0; i < 256; i++) mem.m[i] = HLT;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    slp();
    // Sums: random, then overflow and carry corners last
    for (int t = 0; t < 6; t++) begin
      a = t == 4 ? 32'h7fffffff : t == 5 ? 32'hffffffff : xs();
      b = t > 3 ? 32'h1 : xs();
      hw(6'h01, a);
      hw(6'h02, b);
      run({{`OP_ADD_R, 10'h041}, {5{HLT}}});
      q = a + b;
      fl = {q < a, a[31] == b[31] && q[31] != a[31], q[31], q == 0};
      chk(6'h02, q);
      chk(`HOST_STATUS, st());
      cmp({28'h0, carry_flag, overflow_flag, sign_flag, zero_flag}, {28'h0, fl});
    end
    // And keeps the carry, then interrupts are enabled
    a = xs();
    b = xs();
    hw(6'h01, a);
    hw(6'h02, b);
    run({{`OP_AND_R, 10'h041}, {`OP_INTCTL, 10'h001}, {4{HLT}}});
    q = a & b;
    fl = {fl[3], 1'b0, q[31], q == 0};
    ie = 1'b1;
    chk(6'h02, q);
    chk(`HOST_STATUS, st());
    // Unsigned divide, quotient then copied to a system register
    a = (xs() >> 20) | 32'h1;
    b = xs();
    hw(6'h01, a);
    hw(6'h02, b);
    run({{`OP_UDIV, 10'h041}, {`OP_SRLD, 10'h047}, {4{HLT}}});
    q = b / a;
    fl = {fl[3], 1'b0, q[31], q == 0};
    chk(6'h02, q);
    chk(6'h1e, b % a);
    chk(`HOST_STATUS, st());
    cmp(sysreg_wdata, q);
    cmp({27'h0, sysreg_num}, 32'h7);
    // Byte load from an odd address with the sign bit set
    q = xs() | 32'h8000_0080;
    mem.m[8'hf8] = {q[7:0], 8'h00};
    hw(6'h01, 32'h1f0);
    run({{6'h34, 10'h061}, 16'h0001, {4{HLT}}});
    chk(6'h03, {{24{q[7]}}, q[7:0]});
    // Port halfword at an odd address: aligned, no sign copy
    mem.m[8'hf9] = q[31:16];
    run({{6'h39, 10'h081}, 16'h0003, {4{HLT}}});
    chk(6'h04, {16'h0, q[31:16]});
    run({{`OP_JLNK, 10'h000}, 16'h0008, {4{HLT}}});
    chk(6'h1f, 32'h6);
    chk(`HOST_PC, 32'hc);
    chk(6'h30, 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
